// ==== verilog/amc_pkg.sv ====
`default_nettype none
package amc_pkg;
  // register map, 7-bit addresses
  localparam logic [6:0] OMS_ADDR   = 7'h26;
  localparam logic [6:0] STAT_ADDR  = 7'h30;
  localparam logic [6:0] TEMP_LO    = 7'h31;
  localparam logic [6:0] TEMP_HI    = 7'h32;
  localparam logic [7:0] OMS_RESET  = 8'h00;
  // operating_mode_select fields
  localparam int DSM_LSB  = 0;
  localparam int SAR_LSB  = 2;
  localparam int RNG_LSB  = 4;
  localparam int TEN_BIT  = 7;
  // sigma_delta_path mode codes
  localparam logic [1:0] DSM_OFF = 2'h0;
  localparam logic [1:0] HIGH_PERFORMANCE_MODE = 2'h1;
  localparam logic [1:0] REDUCED_BANDWIDTH_MODE = 2'h2;
  localparam logic [1:0] LOW_POWER_MODE = 2'h3;
  // successive_approx_path mode codes
  localparam logic [1:0] SAR_OFF = 2'h0;
  localparam logic [1:0] VERY_LOW_POWER_MODE = 2'h1;
  localparam logic [1:0] ULTRA_LOW_POWER_MODE = 2'h2;
  localparam logic [1:0] HEART_SOUNDS_MODE = 2'h3;
  // range codes
  localparam logic [1:0] RNG_15G = 2'h0;
  localparam logic [1:0] RNG_30G = 2'h1;
  localparam logic [1:0] RNG_60G = 2'h2;
  // stream word kinds
  localparam logic [1:0] KIND_DSM  = 2'h1;
  localparam logic [1:0] KIND_SAR  = 2'h2;
  localparam logic [1:0] KIND_TEMP = 2'h3;
  // timing
  localparam int unsigned CLK_HZ     = 20000000;
  localparam int unsigned SETTLE_MS  = 2;
  localparam int unsigned SETTLE_CYC = CLK_HZ / 1000 * SETTLE_MS;
  localparam int unsigned TEMP_HZ    = 100;
  localparam int unsigned TEMP_CYC   = CLK_HZ / TEMP_HZ;
  localparam logic [3:0]  SPI_LAST   = 4'hF;
  localparam logic [3:0]  SPI_ADDR   = 4'h7;
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_SETTLE  = 3'b010,
    ST_MEAS    = 3'b100
  } amc_state_t;
endpackage
`default_nettype wire

// ==== verilog/amc_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - high-performance, reduced-bandwidth, low-power modes use the 16-bit sigma-delta path.
// - very-low, ultra-low power and heart-sounds modes use the 12-bit SUCCESSIVE_APPROX_PATH path.
// - standby suspends measurement, keeps buffered words, raises no new events.
// - after reset the block is in standby with both paths off.
// - one sigma-delta and one SUCCESSIVE_APPROX_PATH mode may run together, or each alone.
// - ranges of 15, 30 and 60 g select the converter sensitivity.
// - operating mode is chosen by writing register 0x26.
// - temperature is carried as a 12-bit reading.
// - when enabled, temperature words enter the buffer beside acceleration words.
// - while temperature is enabled, its output register and buffer update together with acceleration samples.
// - temperature refreshes at a fixed 100 Hz while its channel is enabled.
// - between fresh temperature samples the last value is repeated.
// - axis values pass unchanged, so positive acceleration reads larger.
module amc_ctrl
  import amc_pkg::*;
#(
  parameter int unsigned SETTLE_N = SETTLE_CYC,
  parameter int unsigned TEMP_N   = TEMP_CYC
) (
  input  wire logic        clk_sys_i,     // 20 MHz
  input  wire logic        sys_rst_i,     // sync, high
  input  wire logic        spi_sclk_i,    // serial clock pin
  input  wire logic        spi_cs_n_i,    // chip select pin
  input  wire logic        spi_mosi_i,    // serial data in pin
  output logic             spi_miso_o,    // serial data out
  output logic             spi_miso_oe_n_o, // low while driving
  input  wire logic [15:0] dsm_sample_i,  // sigma-delta result
  input  wire logic        dsm_valid_i,   // result valid
  output logic             dsm_ready_o,   // result taken
  input  wire logic [11:0] sar_sample_i,  // SUCCESSIVE_APPROX_PATH result
  input  wire logic        sar_valid_i,   // result valid
  output logic             sar_ready_o,   // result taken
  input  wire logic [11:0] temp_sample_i, // temperature sensor
  output logic [1:0]       dsm_mode_o,    // sigma-delta path mode
  output logic [1:0]       sar_mode_o,    // SUCCESSIVE_APPROX_PATH path mode
  output logic [1:0]       range_o,       // full-scale range
  output logic             temp_en_o,     // temperature channel on
  output logic [17:0]      out_data_o,    // {kind, value}
  output logic             out_valid_o,   // word present
  input  wire logic        out_ready_i    // receiver accepts
);

  ////////////////////////////////////////////////////////////////
  // serial configuration port, mode 0, 16-bit frames
  logic [1:0]  sclk_sync_q;
  logic [1:0]  cs_sync_q;
  logic [1:0]  mosi_sync_q;
  logic        sclk_prev_q;
  logic [3:0]  bit_cnt_q;
  logic [14:0] shin_q;
  logic [7:0]  shout_q;
  logic        miso_q;
  logic        miso_oe_n_q;
  logic [7:0]  oms_q;
  logic [11:0] temp_hold_q;
  logic [11:0] temp_out_q;
  amc_state_t  st_q;
  amc_state_t  st_d;

  wire sclk_rise = sclk_sync_q[1] & ~sclk_prev_q;
  wire sclk_fall = ~sclk_sync_q[1] & sclk_prev_q;
  wire cs_act    = ~cs_sync_q[1];
  wire mosi_s    = mosi_sync_q[1];
  wire [6:0] rd_addr  = {shin_q[5:0], mosi_s};
  wire       rd_req   = shin_q[6];
  wire       rd_load  = cs_act & sclk_rise & (bit_cnt_q == SPI_ADDR) & rd_req;
  wire       wr_cmt   = cs_act & sclk_rise & (bit_cnt_q == SPI_LAST) & ~shin_q[14];
  wire [6:0] wr_addr  = shin_q[13:7];
  wire [7:0] wr_data  = {shin_q[6:0], mosi_s};
  wire [1:0] dsm_sel  = oms_q[DSM_LSB +: 2];
  wire [1:0] sar_sel  = oms_q[SAR_LSB +: 2];
  wire       dsm_on   = (dsm_sel != DSM_OFF) & (st_q != ST_STANDBY);
  wire       sar_on   = (sar_sel != SAR_OFF) & (st_q != ST_STANDBY);
  wire       any_meas = (dsm_sel != DSM_OFF) | (sar_sel != SAR_OFF);
  wire       temp_en  = oms_q[TEN_BIT] & any_meas;
  wire [7:0] stat_val = {5'h00, st_q == ST_MEAS, sar_on, dsm_on};
  wire [7:0] rd_val   = (rd_addr == OMS_ADDR)  ? oms_q :
                        (rd_addr == STAT_ADDR) ? stat_val :
                        (rd_addr == TEMP_LO)   ? temp_out_q[7:0] :
                        (rd_addr == TEMP_HI)   ? {4'h0, temp_out_q[11:8]} : 8'h00;

  always_ff @(posedge clk_sys_i) begin
    sclk_sync_q <= {sclk_sync_q[0], spi_sclk_i};
    cs_sync_q   <= {cs_sync_q[0], spi_cs_n_i};
    mosi_sync_q <= {mosi_sync_q[0], spi_mosi_i};
    sclk_prev_q <= sclk_sync_q[1];
  end

  // port runs in every state, standby included
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !cs_act) begin
      bit_cnt_q   <= 4'h0;
      miso_oe_n_q <= 1'b1;
    end else if (sclk_rise) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      shin_q    <= {shin_q[13:0], mosi_s};
    end
    if (rd_load) begin
      shout_q     <= rd_val;
      miso_oe_n_q <= 1'b0;
    end else if (cs_act && sclk_fall && !miso_oe_n_q) begin
      miso_q  <= shout_q[7];
      shout_q <= {shout_q[6:0], 1'b0};
    end
    if (sys_rst_i) begin
      miso_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      oms_q <= OMS_RESET;
    end else if (wr_cmt && wr_addr == OMS_ADDR) begin
      oms_q <= wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////
  // standby / settle / measure
  logic [17:0] set_cnt_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_STANDBY: begin
        if (any_meas) begin
          st_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (!any_meas) begin
          st_d = ST_STANDBY;
        end else if (set_cnt_q == 18'(SETTLE_N - 1)) begin
          st_d = ST_MEAS;
        end
      end
      ST_MEAS: begin
        if (!any_meas) begin
          st_d = ST_STANDBY;
        end
      end
      default: st_d = ST_STANDBY;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      st_q      <= ST_STANDBY;
      set_cnt_q <= 18'h00000;
    end else begin
      st_q      <= st_d;
      set_cnt_q <= (st_q == ST_SETTLE) ? set_cnt_q + 18'h00001 : 18'h00000;
    end
  end

  // paths and range follow the register; the register only changes whole
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dsm_mode_o <= DSM_OFF;
      sar_mode_o <= SAR_OFF;
      range_o    <= RNG_15G;
      temp_en_o  <= 1'b0;
    end else begin
      dsm_mode_o <= dsm_sel;
      sar_mode_o <= sar_sel;
      range_o    <= oms_q[RNG_LSB +: 2];
      temp_en_o  <= temp_en;
    end
  end

  ////////////////////////////////////////////////////////////////
  // temperature at a fixed rate, held between refreshes
  logic [17:0] tmp_cnt_q;
  wire         tmp_tick = temp_en & (tmp_cnt_q == 18'(TEMP_N - 1));

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !temp_en) begin
      tmp_cnt_q <= 18'h00000;
    end else begin
      tmp_cnt_q <= tmp_tick ? 18'h00000 : tmp_cnt_q + 18'h00001;
    end
    if (sys_rst_i) begin
      temp_hold_q <= 12'h000;
    end else if (tmp_tick) begin
      temp_hold_q <= temp_sample_i;
    end
  end

  ////////////////////////////////////////////////////////////////
  // intake: one word per cycle, paths alternate when both run
  logic        dsm_rdy_q;
  logic        sar_rdy_q;
  logic        turn_q;
  logic        pend_q;
  logic [1:0]  cnt_q;
  logic [17:0] e0_q;
  logic [17:0] e1_q;
  logic        ov_q;

  wire dsm_take = dsm_valid_i & dsm_rdy_q & dsm_on;
  wire sar_take = sar_valid_i & sar_rdy_q & sar_on;
  wire push_acc = dsm_take | sar_take;
  wire push     = push_acc | pend_q;
  wire pop      = ov_q & out_ready_i;
  // sign extension keeps polarity, positive g reads larger
  wire [15:0] sar_ext = {{4{sar_sample_i[11]}}, sar_sample_i};
  wire [17:0] din = pend_q ? {KIND_TEMP, 4'h0, temp_out_q} :
                    dsm_take ? {KIND_DSM, dsm_sample_i} : {KIND_SAR, sar_ext};
  wire [1:0] cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  wire       pend_d = push_acc & temp_en;
  // accept only into an empty buffer, so the paired temp word always fits
  wire       room = (cnt_d == 2'h0) & ~pend_d;
  wire       dsm_rdy_d = room & dsm_on & (~sar_on | ~turn_q);
  wire       sar_rdy_d = room & sar_on & (~dsm_on | turn_q);
  wire [17:0] e0_d = pop ? ((cnt_q == 2'h2) ? e1_q : din) :
                     (push && cnt_q == 2'h0) ? din : e0_q;
  wire        e1_ld = push & (((cnt_q == 2'h1) & ~pop) | ((cnt_q == 2'h2) & pop));

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dsm_rdy_q <= 1'b0;
      sar_rdy_q <= 1'b0;
      turn_q    <= 1'b0;
      pend_q    <= 1'b0;
      cnt_q     <= 2'h0;
      ov_q      <= 1'b0;
      e0_q      <= 18'h00000;
      e1_q      <= 18'h00000;
    end else begin
      dsm_rdy_q <= dsm_rdy_d;
      sar_rdy_q <= sar_rdy_d;
      turn_q    <= ~turn_q;
      pend_q    <= pend_d;
      cnt_q     <= cnt_d;
      ov_q      <= (cnt_d != 2'h0);
      e0_q      <= e0_d;
      if (e1_ld) begin
        e1_q <= din;
      end
    end
  end

  // temp output register moves with each accepted axis sample while temp_en is set
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      temp_out_q <= 12'h000;
    end else if (push_acc && temp_en) begin
      temp_out_q <= temp_hold_q;
    end
  end

  assign spi_miso_o      = miso_q;
  assign spi_miso_oe_n_o = miso_oe_n_q;
  assign dsm_ready_o     = dsm_rdy_q;
  assign sar_ready_o     = sar_rdy_q;
  assign out_valid_o     = ov_q;
  assign out_data_o      = e0_q;

  ////////////////////////////////////////////////////////////////
  // checks
  chk_reset_standby: assert property (@(posedge clk_sys_i)
    $past(sys_rst_i) && !sys_rst_i |-> st_q == ST_STANDBY && oms_q == OMS_RESET && !ov_q)
    else $error("not in standby after reset");
  chk_standby_idle: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    st_q == ST_STANDBY && $past(st_q) == ST_STANDBY |-> !dsm_rdy_q && !sar_rdy_q && !push_acc)
    else $error("intake while in standby");
  chk_dsm_route: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    dsm_take |-> dsm_sel != DSM_OFF ##1 cnt_q != 2'h0)
    else $error("sigma-delta word without its mode");
  chk_sar_route: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sar_take |-> sar_sel != SAR_OFF && din == {KIND_SAR, sar_ext})
    else $error("SUCCESSIVE_APPROX_PATH word without its mode");
  chk_one_each: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !(dsm_rdy_q && sar_rdy_q) && cnt_q != 2'h3)
    else $error("both paths granted at once");
  chk_settle_time: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    st_q == ST_MEAS && $past(st_q) == ST_SETTLE |-> $past(set_cnt_q) == 18'(SETTLE_N - 1))
    else $error("settle wait wrong length");
  chk_mode_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_cmt && wr_addr == OMS_ADDR |=> oms_q == $past(wr_data) ##1 range_o == $past(oms_q[RNG_LSB +: 2]))
    else $error("mode write lost");
  chk_temp_pair: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    push_acc && temp_en |=> pend_q && din[17:16] == KIND_TEMP && temp_out_q == $past(temp_hold_q))
    else $error("temperature word not paired");
  chk_temp_tick: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    tmp_tick |=> temp_hold_q == $past(temp_sample_i) && tmp_cnt_q == 18'h00000)
    else $error("temperature refresh missed");
  chk_temp_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !tmp_tick |=> $stable(temp_hold_q))
    else $error("temperature changed between ticks");
  chk_stop_intake: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_cmt && wr_addr == OMS_ADDR && wr_data[3:0] == 4'h0 |=> ##1 !push_acc && !dsm_rdy_q && !sar_rdy_q)
    else $error("intake after standby write");

endmodule // amc_ctrl
`default_nettype wire

// ==== tb/amc_spi_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module amc_spi_host (
  input  wire logic clk_sys_i, // system clock
  output logic      sclk_o,    // serial clock
  output logic      cs_n_o,    // chip select
  output logic      mosi_o,    // data to device
  input  wire logic miso_i     // resolved data line
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // half period of 5 clocks, above the 4-clock floor; sclk idles low
  task automatic frame(input logic [15:0] w, output logic [7:0] r);
    r = 8'h00;
    @(negedge clk_sys_i);
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi_o = w[i];
      repeat (5) @(negedge clk_sys_i);
      sclk_o = 1'b1;
      if (i < 8) r[i] = miso_i;
      repeat (5) @(negedge clk_sys_i);
      sclk_o = 1'b0;
    end
    repeat (5) @(negedge clk_sys_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // released line: no stale bit
    repeat (5) @(negedge clk_sys_i);
  endtask
endmodule // amc_spi_host
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import amc_pkg::*;
  localparam int SN = 20;
  localparam int TN = 50;
  logic        clk_sys_i, sys_rst_i, sclk, cs_n, mosi, miso, oe_n;
  logic [15:0] dsm_d;
  logic [11:0] sar_d, temp_d;
  logic        dsm_v, dsm_r, sar_v, sar_r, ten, ovalid, oready;
  logic [1:0]  dmode, smode, rng;
  logic [17:0] odata;
  logic [7:0]  r;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  wire         miso_w = oe_n ? 1'b1 : miso; // pull-up when released

  amc_spi_host host (.clk_sys_i(clk_sys_i), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w));
  amc_ctrl #(.SETTLE_N(SN), .TEMP_N(TN)) uut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(oe_n), .dsm_sample_i(dsm_d),
    .dsm_valid_i(dsm_v), .dsm_ready_o(dsm_r), .sar_sample_i(sar_d), .sar_valid_i(sar_v),
    .sar_ready_o(sar_r), .temp_sample_i(temp_d), .dsm_mode_o(dmode), .sar_mode_o(smode),
    .range_o(rng), .temp_en_o(ten), .out_data_o(odata), .out_valid_o(ovalid), .out_ready_i(oready));

  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.frame({1'b0, a, d}, x);
    repeat (4) @(negedge clk_sys_i);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string m);
    host.frame({1'b1, a, 8'h00}, r);
    chk({10'h000, r}, {10'h000, e}, m);
  endtask
  // s high offers on the sar path; holds valid until ready is seen
  task automatic offer(input logic s, input logic [15:0] v);
    int n;
    n = 0;
    @(negedge clk_sys_i);
    if (s) begin
      sar_d = v[11:0];
      sar_v = 1'b1;
    end else begin
      dsm_d = v;
      dsm_v = 1'b1;
    end
    // ready is registered: seen settled here, the next rising edge takes the word
    while ((s ? sar_r : dsm_r) !== 1'b1 && n < 100) begin
      @(negedge clk_sys_i);
      n++;
    end
    @(negedge clk_sys_i);
    sar_v = 1'b0;
    dsm_v = 1'b0;
    if (n >= 100) chk(18'h0, 18'h1, "sample never taken");
  endtask
  task automatic take(input logic [17:0] e, input string m);
    int n;
    n = 0;
    while (ovalid !== 1'b1 && n < 100) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk(odata, e, m);
    oready = 1'b1;
    @(negedge clk_sys_i);
    oready = 1'b0;
    // one idle cycle, so a following take never re-raises ready in this step
    @(negedge clk_sys_i);
  endtask
  task automatic idle_chk();
    dsm_v = 1'b1;
    sar_v = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    chk({15'h0, dsm_r, sar_r, ovalid}, 18'h0, "standby intake");
    dsm_v = 1'b0;
    sar_v = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [11:0] v;
    {dsm_d, sar_d, temp_d, dsm_v, sar_v, oready} = '0;
    sys_rst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk({9'h000, dmode, smode, rng, ten, ovalid, oe_n}, 18'h1, "reset outputs");
    rd(OMS_ADDR, OMS_RESET, "mode reset");
    rd(7'h10, 8'h00, "unmapped read");
    idle_chk();
    $display("test reset done");
    for (int m = 1; m < 4; m++) begin
      wr(OMS_ADDR, {2'b00, 2'(m - 1), 2'b00, 2'(m)});
      chk({12'h000, dmode, smode, rng}, {12'h0, 2'(m), 2'b00, 2'(m - 1)}, "dsm mode");
      rd(OMS_ADDR, {2'b00, 2'(m - 1), 2'b00, 2'(m)}, "mode readback");
      repeat (SN) @(negedge clk_sys_i);
      offer(1'b0, 16'h8000 + 16'(m));
      take({KIND_DSM, 16'h8000 + 16'(m)}, "dsm word");
      wr(OMS_ADDR, 8'h00);
      v = m[0] ? (12'hF00 | 12'(m)) : (12'h0F0 | 12'(m));
      wr(OMS_ADDR, {4'h0, 2'(m), 2'b00});
      chk({14'h0000, dmode, smode}, {14'h0, 2'b00, 2'(m)}, "sar mode");
      repeat (SN) @(negedge clk_sys_i);
      offer(1'b1, {4'h0, v});
      take({KIND_SAR, {4{v[11]}}, v}, "sar word");
      wr(OMS_ADDR, 8'h00);
    end
    $display("test modes done");
    wr(OMS_ADDR, 8'h05);
    repeat (SN) @(negedge clk_sys_i);
    rd(STAT_ADDR, 8'h07, "both active settled");
    offer(1'b0, 16'h1234);
    take({KIND_DSM, 16'h1234}, "concurrent dsm");
    offer(1'b1, 16'h0456);
    take({KIND_SAR, 16'h0456}, "concurrent sar");
    wr(OMS_ADDR, 8'h00);
    $display("test concurrent done");
    temp_d = 12'hABC;
    wr(OMS_ADDR, 8'h81);
    chk({17'h0, ten}, 18'h1, "temp enable");
    repeat (TN + 5) @(negedge clk_sys_i);
    offer(1'b0, 16'h0011);
    repeat (5) @(negedge clk_sys_i);
    chk({ovalid, dsm_r, odata[15:0]}, {2'b10, 16'h0011}, "stalled head");
    take({KIND_DSM, 16'h0011}, "accel before temp");
    take({KIND_TEMP, 16'h0ABC}, "temp word");
    rd(TEMP_LO, 8'hBC, "temp low");
    rd(TEMP_HI, 8'h0A, "temp high");
    offer(1'b0, 16'h0022);
    take({KIND_DSM, 16'h0022}, "second accel");
    take({KIND_TEMP, 16'h0ABC}, "repeated temp");
    temp_d = 12'h123;
    repeat (TN + 5) @(negedge clk_sys_i);
    offer(1'b0, 16'h0033);
    take({KIND_DSM, 16'h0033}, "third accel");
    take({KIND_TEMP, 16'h0123}, "fresh temp");
    $display("test temperature done");
    wr(OMS_ADDR, 8'h00);
    chk({13'h0000, dmode, smode, ten}, 18'h0, "standby outputs");
    idle_chk();
    rd(OMS_ADDR, 8'h00, "standby readback");
    $display("test standby done");
    // reset again while both paths are on and still settling, with temperature on
    wr(OMS_ADDR, 8'h96);
    chk({12'h000, dmode, smode, rng}, {12'h000, 2'h2, 2'h1, 2'h1}, "mixed modes");
    sys_rst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk({9'h000, dmode, smode, rng, ten, ovalid, oe_n}, 18'h1, "mid-run reset");
    rd(OMS_ADDR, OMS_RESET, "mode after reset");
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
